//--- src/uart_enhanced_regs_rx_interrupt.sv
// Register bank, bank select and receive interrupt logic of the serial transceiver
`include "uart_enh_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module uart_enhanced_regs_rx_interrupt
    import uart_enh_pkg::*;
#(
    parameter logic [7:0] REVISION_CODE = 8'h01, // Arbitrary value
    parameter logic [7:0] IDENT_CODE    = 8'h5A  // Arbitrary value
) (
    input  wire logic        core_clk_i,
    input  wire logic        arst_n_i,
    // Host register port
    input  var  bus_req_type bus_i,
    output logic [7:0]       rdata_o,
    // Receive path
    input  var  rx_side_type rx_i,
    output logic             rx_pop_o,
    output logic             rx_fifo_reset_o,
    // Transmit path
    input  wire logic        tx_ready_i,
    output logic             tx_load_o,
    output logic [7:0]       tx_data_o,
    output logic             tx_fifo_reset_o,
    // Other interrupt sources and line status
    input  wire logic        line_err_i,
    input  wire logic        modem_chg_i,
    input  wire logic [6:0]  line_status_i,
    output logic             isr_read_o,
    output logic             lsr_read_o,
    // Configuration seen by the rest of the transceiver
    output logic [7:0]       line_ctrl_o,
    output logic [15:0]      divisor_o,
    output logic [7:0]       divisor_frac_o,
    output logic [7:0]       trigger_level_o,
    output logic [7:0]       feature_ctrl_o,
    output logic [7:0]       enh_func_o,
    output logic             fifo_enable_o,
    output logic             irq_o
);

    // Register storage
    logic [7:0] line_control_reg_q;
    logic [7:0] interrupt_mask_reg_q;
    logic [7:0] fifo_control_reg_q;
    logic [7:0] divisor_low_q;
    logic [7:0] divisor_high_q;
    logic [7:0] divisor_fraction_mode_q;
    logic [7:0] trigger_level_setting_q;
    logic [7:0] feature_control_q;
    logic [7:0] enhanced_function_q;
    logic [7:0] resume_char_one_q;
    logic [7:0] resume_char_two_q;
    logic [7:0] pause_char_one_q;
    logic [7:0] pause_char_two_q;
    logic [7:0] tx_data_q;
    logic [7:0] rdata_q;
    logic       data_ready_q;
    logic       rx_fifo_reset_q;
    logic       tx_fifo_reset_q;

    // Derived controls
    bank_type   bank;
    logic       enh_unlock;
    logic       fifo_en;
    logic       trigger_level_setting_hit;
    logic       rx_level_src;
    logic       rx_timeout_src;
    logic       tx_src;
    logic       line_src;
    logic       modem_src;
    logic [3:0] int_code;
    logic       int_pending;
    logic [7:0] interrupt_status_reg;
    logic [7:0] line_status_reg;
    logic [7:0] read_mux;
    logic       wr_data;
    logic       rd_data;
    logic       wr_mask;
    logic       wr_fifo;
    logic       wr_lctrl;

    assign enh_unlock = enhanced_function_q[`EFR_ENH_BIT];
    assign fifo_en    = fifo_control_reg_q[`FCR_EN_BIT];

    // Bank select; the enhanced key takes precedence over the divisor bit
    always_comb begin
        if (line_control_reg_q == `LCTRL_ENH_KEY) begin
            bank = BANK_ENHANCED;
        end else if (line_control_reg_q[`LCTRL_DIV_BIT]) begin
            bank = BANK_DIVISOR;
        end else begin
            bank = BANK_NORMAL;
        end
    end

    // Access decode for the normal bank and the line control register
    assign wr_data  = bus_i.wr && (bank == BANK_NORMAL) && (bus_i.addr == `OFS_DATA);
    assign rd_data  = bus_i.rd && (bank == BANK_NORMAL) && (bus_i.addr == `OFS_DATA);
    assign wr_mask  = bus_i.wr && (bank == BANK_NORMAL) && (bus_i.addr == `OFS_IMASK);
    assign wr_fifo  = bus_i.wr && (bank == BANK_NORMAL) && (bus_i.addr == `OFS_ISTAT);
    assign wr_lctrl = bus_i.wr && (bus_i.addr == `OFS_LCTRL);

    // Line control is reachable from every bank, else the host could never leave one
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            line_control_reg_q <= `RST_LCTRL;
        end else if (wr_lctrl) begin
            line_control_reg_q <= bus_i.wdata;
        end
    end

    // Interrupt mask; upper bits locked until the enhanced enable is set
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            interrupt_mask_reg_q <= `RST_BYTE;
        end else if (wr_mask) begin
            if (enh_unlock) begin
                interrupt_mask_reg_q <= bus_i.wdata;
            end else begin
                interrupt_mask_reg_q <= (bus_i.wdata & `IMASK_BASE_MASK)
                                      | (interrupt_mask_reg_q & ~`IMASK_BASE_MASK);
            end
        end
    end

    // FIFO control; the reset bits are self-clearing one-cycle pulses
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fifo_control_reg_q <= `RST_BYTE;
            rx_fifo_reset_q    <= 1'b0;
            tx_fifo_reset_q    <= 1'b0;
        end else begin
            rx_fifo_reset_q <= wr_fifo && bus_i.wdata[`FCR_RXRST_BIT];
            tx_fifo_reset_q <= wr_fifo && bus_i.wdata[`FCR_TXRST_BIT];
            if (wr_fifo) begin
                if (enh_unlock) begin
                    fifo_control_reg_q <= bus_i.wdata;
                end else begin
                    fifo_control_reg_q <= (bus_i.wdata & `FCR_BASE_MASK)
                                        | (fifo_control_reg_q & ~`FCR_BASE_MASK);
                end
            end
        end
    end

    // Divisor bank writes
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            divisor_low_q           <= `RST_BYTE;
            divisor_high_q          <= `RST_BYTE;
            divisor_fraction_mode_q <= `RST_BYTE;
        // divisor writes only in divisor bank
        end else if (bus_i.wr && (bank == BANK_DIVISOR)) begin
            case (bus_i.addr)
                `OFS_DATA: begin
                    divisor_low_q <= bus_i.wdata;
                end
                `OFS_IMASK: begin
                    divisor_high_q <= bus_i.wdata;
                end
                `OFS_ISTAT: begin
                    // Fraction and mode bits also need the enhanced enable
                    if (enh_unlock) begin
                        divisor_fraction_mode_q <= bus_i.wdata;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Enhanced bank writes
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trigger_level_setting_q <= `RST_BYTE;
            feature_control_q       <= `RST_BYTE;
            enhanced_function_q     <= `RST_BYTE;
            resume_char_one_q       <= `RST_BYTE;
            resume_char_two_q       <= `RST_BYTE;
            pause_char_one_q        <= `RST_BYTE;
            pause_char_two_q        <= `RST_BYTE;
        end else if (bus_i.wr && (bank == BANK_ENHANCED)) begin
            case (bus_i.addr)
                `OFS_DATA: begin
                    trigger_level_setting_q <= bus_i.wdata;
                end
                `OFS_IMASK: begin
                    feature_control_q <= bus_i.wdata;
                end
                `OFS_ISTAT: begin
                    enhanced_function_q <= bus_i.wdata;
                end
                `OFS_RESUME1: begin
                    resume_char_one_q <= bus_i.wdata;
                end
                `OFS_RESUME2: begin
                    resume_char_two_q <= bus_i.wdata;
                end
                `OFS_PAUSE1: begin
                    pause_char_one_q <= bus_i.wdata;
                end
                `OFS_PAUSE2: begin
                    pause_char_two_q <= bus_i.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // Transmit holding byte, held for the transmitter after the load pulse
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_data_q <= `RST_BYTE;
        end else if (wr_data) begin
            tx_data_q <= bus_i.wdata;
        end
    end

    // Data-ready flag; a new character beats an emptying FIFO in the same cycle
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            data_ready_q <= 1'b0;
        end else if (rx_i.push) begin
            data_ready_q <= 1'b1;
        end else if (rx_i.fill == `RST_BYTE) begin
            data_ready_q <= 1'b0;
        end
    end

    rx_trigger_compare #(
        .WIDTH (8)
    ) u_trigger_level_setting (
        .fill_i  (rx_i.fill),
        .level_i (trigger_level_setting_q),
        .hit_o   (trigger_level_setting_hit)
    );

    // Interrupt sources after masking
    // one mask bit per source; timeout shares the receive bit
    assign line_src       = interrupt_mask_reg_q[`IM_LINE_BIT] && line_err_i;
    assign rx_timeout_src = interrupt_mask_reg_q[`IM_RX_BIT] && rx_i.timeout;
    assign tx_src         = interrupt_mask_reg_q[`IM_TX_BIT] && tx_ready_i;
    assign modem_src      = interrupt_mask_reg_q[`IM_MODEM_BIT] && modem_chg_i;

    always_comb begin
        if (fifo_en) begin
            rx_level_src = interrupt_mask_reg_q[`IM_RX_BIT] && trigger_level_setting_hit;
        end else begin
            rx_level_src = interrupt_mask_reg_q[`IM_RX_BIT] && data_ready_q;
        end
    end

    // receive ready sits at level three
    rx_int_encoder u_enc (
        .line_i     (line_src),
        .timeout_i  (rx_timeout_src),
        .rx_ready_i (rx_level_src),
        .tx_ready_i (tx_src),
        .modem_i    (modem_src),
        .code_o     (int_code),
        .pending_o  (int_pending)
    );

    // source code shown in bits 3:0
    assign interrupt_status_reg = {fifo_en, fifo_en, 2'b00, int_code};
    assign line_status_reg      = {line_status_i, data_ready_q};

    // Read multiplexer per bank; unmapped offsets read zero
    always_comb begin
        read_mux = `RST_BYTE;
        case (bank)
            BANK_ENHANCED: begin
                case (bus_i.addr)
                    `OFS_DATA:    read_mux = rx_i.fill;
                    `OFS_IMASK:   read_mux = feature_control_q;
                    `OFS_ISTAT:   read_mux = enhanced_function_q;
                    `OFS_LCTRL:   read_mux = line_control_reg_q;
                    `OFS_RESUME1: read_mux = resume_char_one_q;
                    `OFS_RESUME2: read_mux = resume_char_two_q;
                    `OFS_PAUSE1:  read_mux = pause_char_one_q;
                    `OFS_PAUSE2:  read_mux = pause_char_two_q;
                    default:      read_mux = `RST_BYTE;
                endcase
            end
            BANK_DIVISOR: begin
                // Identity bytes only show while the whole divisor is zero
                case (bus_i.addr)
                    `OFS_DATA: begin
                        read_mux = ({divisor_high_q, divisor_low_q} == 16'h0000) ? REVISION_CODE : divisor_low_q;
                    end
                    `OFS_IMASK: begin
                        read_mux = ({divisor_high_q, divisor_low_q} == 16'h0000) ? IDENT_CODE : divisor_high_q;
                    end
                    `OFS_ISTAT: read_mux = divisor_fraction_mode_q;
                    `OFS_LCTRL: read_mux = line_control_reg_q;
                    `OFS_LSTAT: read_mux = line_status_reg;
                    default:    read_mux = `RST_BYTE;
                endcase
            end
            BANK_NORMAL: begin
                case (bus_i.addr)
                    `OFS_DATA:  read_mux = rx_i.head_data;
                    `OFS_IMASK: read_mux = interrupt_mask_reg_q;
                    `OFS_ISTAT: read_mux = interrupt_status_reg;
                    `OFS_LCTRL: read_mux = line_control_reg_q;
                    `OFS_LSTAT: read_mux = line_status_reg;
                    default:    read_mux = `RST_BYTE;
                endcase
            end
            default: begin
                read_mux = `RST_BYTE;
            end
        endcase
    end

    // Read data captured on the strobe and held until the next read
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= `RST_BYTE;
        end else if (bus_i.rd) begin
            rdata_q <= read_mux;
        end
    end

    // Side-effect strobes for the receiver, transmitter and clearing logic
    assign rx_pop_o   = rd_data;
    assign tx_load_o  = wr_data;
    assign isr_read_o = bus_i.rd && (bank == BANK_NORMAL) && (bus_i.addr == `OFS_ISTAT);
    assign lsr_read_o = bus_i.rd && (bank != BANK_ENHANCED) && (bus_i.addr == `OFS_LSTAT);

    // Outputs
    assign rdata_o         = rdata_q;
    assign tx_data_o       = tx_data_q;
    assign rx_fifo_reset_o = rx_fifo_reset_q;
    assign tx_fifo_reset_o = tx_fifo_reset_q;
    assign line_ctrl_o     = line_control_reg_q;
    assign divisor_o       = {divisor_high_q, divisor_low_q};
    assign divisor_frac_o  = divisor_fraction_mode_q;
    assign trigger_level_o = trigger_level_setting_q;
    assign feature_ctrl_o  = feature_control_q;
    assign enh_func_o      = enhanced_function_q;
    assign fifo_enable_o   = fifo_en;
    // output and status share one source
    assign irq_o           = int_pending;

endmodule : uart_enhanced_regs_rx_interrupt

`default_nettype wire

//--- src/uart_enh_regs.svh
// Register offsets, field positions, reset values and interrupt codes of the register slice
`ifndef UART_ENH_REGS_SVH
`define UART_ENH_REGS_SVH

// Offsets on the three address lines
`define OFS_DATA        3'h0
`define OFS_IMASK       3'h1
`define OFS_ISTAT       3'h2
`define OFS_LCTRL       3'h3
`define OFS_LSTAT       3'h5
`define OFS_RESUME1     3'h4
`define OFS_RESUME2     3'h5
`define OFS_PAUSE1      3'h6
`define OFS_PAUSE2      3'h7

// Line control value that opens the enhanced bank
`define LCTRL_ENH_KEY   8'hBF
`define LCTRL_DIV_BIT   7

// Field positions
`define IM_RX_BIT       0
`define IM_TX_BIT       1
`define IM_LINE_BIT     2
`define IM_MODEM_BIT    3
`define EFR_ENH_BIT     4
`define FCR_EN_BIT      0
`define FCR_RXRST_BIT   1
`define FCR_TXRST_BIT   2
`define LS_READY_BIT    0

// Masks for bits writable without the enhanced enable; the other bits stay locked until it is set
`define IMASK_BASE_MASK 8'h0F
`define FCR_BASE_MASK   8'hC7

// Reset values
`define RST_BYTE        8'h00
`define RST_LCTRL       8'h00

// Interrupt source codes for status bits 3:0
`define ISRC_LINE       4'h6
`define ISRC_TIMEOUT    4'hC
`define ISRC_RECEIVE_READY_SOURCE      4'h4
`define ISRC_TXRDY      4'h2
`define ISRC_MODEM      4'h0
`define ISRC_NONE       4'h1

`endif

//--- src/uart_enh_pkg.sv
// Types shared by the register slice and its helpers
package uart_enh_pkg;

    // One host access on the byte-wide register port
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } bus_req_type;

    // Receive path status that arrives from the FIFO and receiver
    typedef struct packed {
        logic [7:0] fill;
        logic       push;
        logic       timeout;
        logic [7:0] head_data;
    } rx_side_type;

    // Register bank chosen by the line control value
    typedef enum logic [2:0] {
        BANK_NORMAL   = 3'b001,
        BANK_DIVISOR  = 3'b010,
        BANK_ENHANCED = 3'b100
    } bank_type;

endpackage : uart_enh_pkg

//--- src/rx_trigger_compare.sv
// Receive fill versus trigger level comparison
`timescale 1ns/1ps
`default_nettype none

module rx_trigger_compare #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] fill_i,
    input  wire logic [WIDTH-1:0] level_i,
    output logic                  hit_o
);

    // Combinational so the flag drops in the same cycle the fill drops
    assign hit_o = (fill_i >= level_i);

endmodule : rx_trigger_compare

`default_nettype wire

//--- src/rx_int_encoder.sv
// Priority encoder for the interrupt status source field
`include "uart_enh_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rx_int_encoder (
    input  wire logic       line_i,
    input  wire logic       timeout_i,
    input  wire logic       rx_ready_i,
    input  wire logic       tx_ready_i,
    input  wire logic       modem_i,
    output logic [3:0]      code_o,
    output logic            pending_o
);

    // Highest level wins; lower sources wait until it is serviced
    always_comb begin
        pending_o = 1'b1;
        if (line_i) begin
            code_o = `ISRC_LINE;
        end else if (timeout_i) begin
            code_o = `ISRC_TIMEOUT;
        end else if (rx_ready_i) begin
            code_o = `ISRC_RECEIVE_READY_SOURCE;
        end else if (tx_ready_i) begin
            code_o = `ISRC_TXRDY;
        end else if (modem_i) begin
            code_o = `ISRC_MODEM;
        end else begin
            code_o    = `ISRC_NONE;
            pending_o = 1'b0;
        end
    end

endmodule : rx_int_encoder

`default_nettype wire

//--- verif/regs_irq_checker.sv
// Concurrent checks on the ports of the register slice
`timescale 1ns/1ps
`default_nettype none

module regs_irq_checker
    import uart_enh_pkg::*;
(
    input wire logic        core_clk_i,
    input wire logic        arst_n_i,
    input var  bus_req_type bus_i,
    input var  rx_side_type rx_i,
    input wire logic        tx_ready_i,
    input wire logic        line_err_i,
    input wire logic        modem_chg_i,
    input wire logic        rx_pop_o,
    input wire logic        rx_fifo_reset_o,
    input wire logic        tx_load_o,
    input wire logic [7:0]  tx_data_o,
    input wire logic        isr_read_o,
    input wire logic [7:0]  line_ctrl_o,
    input wire logic [15:0] divisor_o,
    input wire logic [7:0]  trigger_level_o,
    input wire logic        fifo_enable_o,
    input wire logic        irq_o
);
    logic [3:0] mask_q;
    logic       any_src;

    // Shadow of the low mask bits; only the normal bank reaches them
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mask_q <= 4'h0;
        end else if (bus_i.wr && bus_i.addr == 3'h1 && !line_ctrl_o[7]) begin
            mask_q <= bus_i.wdata[3:0];
        end
    end

    // Expected request level in FIFO mode; time-out gating is left out on purpose
    assign any_src = (mask_q[0] && rx_i.fill >= trigger_level_o) || (mask_q[1] && tx_ready_i)
                     || (mask_q[2] && line_err_i) || (mask_q[3] && modem_chg_i);

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_tx_write;
        bus_i.wr && bus_i.addr == 3'h0 && !line_ctrl_o[7];
    endsequence
    sequence s_div_write;
        bus_i.wr && bus_i.addr == 3'h0 && line_ctrl_o[7] && line_ctrl_o != 8'hBF;
    endsequence
    sequence s_fcr_write;
        bus_i.wr && bus_i.addr == 3'h2 && !line_ctrl_o[7];
    endsequence

    // Bank selection, strobes and the receive level interrupt
    a_rx_level_irq: assert property (fifo_enable_o && !rx_i.timeout |-> irq_o == any_src)
        else $error("irq level differs from enabled sources");
    a_mask_quiet: assert property (mask_q == 4'h0 && !rx_i.timeout |-> !irq_o)
        else $error("irq raised with all sources masked");
    a_tx_load: assert property (s_tx_write |-> tx_load_o ##1 tx_data_o == $past(bus_i.wdata))
        else $error("transmit byte not loaded");
    a_div_load: assert property (s_div_write |=> divisor_o[7:0] == $past(bus_i.wdata))
        else $error("divisor low not written");
    a_div_no_tx: assert property (s_div_write |-> !tx_load_o)
        else $error("divisor write reached transmitter");
    a_div_locked: assert property (!line_ctrl_o[7] |=> $stable(divisor_o))
        else $error("divisor changed while bank closed");
    a_pop_strobe: assert property (bus_i.rd && bus_i.addr == 3'h0 |-> rx_pop_o == !line_ctrl_o[7])
        else $error("receive pop strobe wrong");
    a_isr_strobe: assert property (bus_i.rd && bus_i.addr == 3'h2 |-> isr_read_o == !line_ctrl_o[7])
        else $error("status read strobe wrong");
    a_fifo_enable: assert property (s_fcr_write |=> fifo_enable_o == $past(bus_i.wdata[0]))
        else $error("FIFO enable not taken");
    a_fifo_reset: assert property (s_fcr_write |=> rx_fifo_reset_o == $past(bus_i.wdata[1]))
        else $error("receive FIFO reset pulse missing");
endmodule : regs_irq_checker

bind uart_enhanced_regs_rx_interrupt regs_irq_checker i_regs_irq_checker (
    .core_clk_i, .arst_n_i, .bus_i, .rx_i, .tx_ready_i, .line_err_i, .modem_chg_i, .rx_pop_o,
    .rx_fifo_reset_o, .tx_load_o, .tx_data_o, .isr_read_o, .line_ctrl_o, .divisor_o,
    .trigger_level_o, .fifo_enable_o, .irq_o
);

`default_nettype wire

//--- verif/host_model.sv
// Host processor model that drives the byte-wide register port
`timescale 1ns/1ps
`default_nettype none

module host_model
    import uart_enh_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic [7:0] rdata_i,
    output var bus_req_type bus_o
);
    initial bus_o = '0;

    // One request, taken at the next edge; address and data inverted once released
    task automatic put(input logic r, input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        bus_o <= '{rd: r, wr: !r, addr: a, wdata: d};
        @(posedge core_clk_i);
        bus_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        #1;
    endtask : put

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        put(1'b0, a, d);
    endtask : wr

    // Read data is valid one cycle after the taking edge
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        put(1'b1, a, 8'h00);
        @(posedge core_clk_i);
        #1 d = rdata_i;
    endtask : rd

    task automatic div_wr(input logic [15:0] v);
        wr(3'h3, 8'h80);
        wr(3'h0, v[7:0]);
        wr(3'h1, v[15:8]);
    endtask : div_wr
endmodule : host_model

`default_nettype wire

//--- verif/uart_enhanced_regs_rx_interrupt_tb.sv
// Self-checking bench for the register slice and its receive interrupt
`timescale 1ns/1ps
`default_nettype none

module uart_enhanced_regs_rx_interrupt_tb;
    import uart_enh_pkg::*;
    localparam logic [7:0] REV = 8'h01; // Arbitrary value
    localparam logic [7:0] IDC = 8'h5A; // Arbitrary value
    logic        core_clk_i  = 1'b0;
    logic        arst_n_i    = 1'b0;
    bus_req_type bus_i;
    rx_side_type rx_i        = '0;
    logic        tx_ready_i  = 1'b0;
    logic        line_err_i  = 1'b0;
    logic        modem_chg_i = 1'b0;
    logic [7:0]  rdata_o;
    logic [7:0]  tx_data_o;
    logic [15:0] divisor_o;
    logic [7:0]  trigger_level_o;
    logic        irq_o;
    int          fail_count  = 0;
    int          n_compared  = 0;

    // 40 MHz clock
    always #12.5 core_clk_i = ~core_clk_i;

    uart_enhanced_regs_rx_interrupt #(.REVISION_CODE(REV), .IDENT_CODE(IDC)) i_uart_enhanced_regs_rx_interrupt (
        .core_clk_i, .arst_n_i, .bus_i, .rdata_o, .rx_i, .rx_pop_o(), .rx_fifo_reset_o(), .tx_ready_i,
        .tx_load_o(), .tx_data_o, .tx_fifo_reset_o(), .line_err_i, .modem_chg_i, .line_status_i(7'h00),
        .isr_read_o(), .lsr_read_o(), .line_ctrl_o(), .divisor_o, .divisor_frac_o(), .trigger_level_o,
        .feature_ctrl_o(), .enh_func_o(), .fifo_enable_o(), .irq_o
    );
    host_model i_host (.core_clk_i, .rdata_i(rdata_o), .bus_o(bus_i));

    task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : check

    task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string n);
        logic [7:0] d;
        i_host.rd(a, d);
        check(n, e, d);
    endtask : rdc

    task automatic chk_irq(input logic e);
        check("irq", {7'h00, e}, {7'h00, irq_o});
    endtask : chk_irq

    // Sources as {timeout, modem, line, transmit}, changed just after an edge
    task automatic set_in(input logic [7:0] f, input logic [3:0] s);
        @(posedge core_clk_i);
        rx_i.fill <= f;
        {rx_i.timeout, modem_chg_i, line_err_i, tx_ready_i} <= s;
        #1;
    endtask : set_in

    // Reset values, then identity readout with divisor at zero
    task automatic t_reset();
        @(posedge core_clk_i);
        arst_n_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        rdc(3'h1, 8'h00, "mask");
        rdc(3'h3, 8'h00, "line ctrl");
        rdc(3'h5, 8'h00, "line status");
        chk_irq(1'b0);
        i_host.wr(3'h3, 8'h80);
        rdc(3'h0, REV, "revision");
        rdc(3'h1, IDC, "identifier");
        i_host.wr(3'h3, 8'h00);
    endtask : t_reset

    task automatic t_divisor();
        i_host.div_wr(16'h1234);
        rdc(3'h0, 8'h34, "divisor low");
        rdc(3'h1, 8'h12, "divisor high");
        i_host.wr(3'h3, 8'h03);
        i_host.wr(3'h0, 8'h55);
        check("divisor out", 8'h34, divisor_o[7:0]);
        check("tx data", 8'h55, tx_data_o);
    endtask : t_divisor

    // Enhanced bank: trigger, enhanced function, flow characters, fill count
    task automatic t_enhanced();
        i_host.wr(3'h3, 8'hBF);
        for (int a = 4; a < 8; a++) rdc(3'(a), 8'h00, "flow char reset");
        i_host.wr(3'h0, 8'h04);
        check("trigger", 8'h04, trigger_level_o);
        i_host.wr(3'h2, 8'h10);
        rdc(3'h2, 8'h10, "enh function");
        for (int a = 4; a < 8; a++) i_host.wr(3'(a), 8'h30 + 8'(a));
        for (int a = 4; a < 8; a++) rdc(3'(a), 8'h30 + 8'(a), "flow char");
        set_in(8'h07, 4'h0);
        rdc(3'h0, 8'h07, "fill count");
        set_in(8'h00, 4'h0);
        i_host.wr(3'h3, 8'h03);
    endtask : t_enhanced

    // Receive level interrupt around a trigger of four
    task automatic t_fifo_irq();
        i_host.wr(3'h2, 8'h00);
        i_host.wr(3'h1, 8'h01);
        set_in(8'h04, 4'h0);
        chk_irq(1'b0);
        rdc(3'h2, 8'h01, "status no fifo");
        i_host.wr(3'h2, 8'h03);
        set_in(8'h03, 4'h0);
        chk_irq(1'b0);
        set_in(8'h04, 4'h0);
        chk_irq(1'b1);
        rdc(3'h2, 8'hC4, "status at level");
        set_in(8'h05, 4'h0);
        chk_irq(1'b1);
        set_in(8'h03, 4'h0);
        chk_irq(1'b0);
        rdc(3'h2, 8'hC1, "status below");
    endtask : t_fifo_irq

    // Each mask bit alone, then priority order with all enabled
    task automatic t_priority();
        logic [7:0] codes [4];
        codes = '{8'hC4, 8'hC2, 8'hC6, 8'hC0};
        set_in(8'h04, 4'h7);
        for (int i = 0; i < 4; i++) begin
            i_host.wr(3'h1, 8'h01 << i);
            rdc(3'h2, codes[i], "single source");
        end
        i_host.wr(3'h1, 8'h0F);
        rdc(3'h2, 8'hC6, "line first");
        set_in(8'h04, 4'h9);
        rdc(3'h2, 8'hCC, "timeout second");
        set_in(8'h04, 4'h1);
        rdc(3'h2, 8'hC4, "rx over tx");
        set_in(8'h00, 4'h5);
        rdc(3'h2, 8'hC2, "tx over modem");
        set_in(8'h04, 4'h7);
        i_host.wr(3'h1, 8'h00);
        chk_irq(1'b0);
        set_in(8'h00, 4'h0);
    endtask : t_priority

    // Data ready flag in non-FIFO mode
    task automatic t_ready();
        i_host.wr(3'h2, 8'h00);
        i_host.wr(3'h1, 8'h01);
        @(posedge core_clk_i);
        rx_i.push <= 1'b1;
        rx_i.fill <= 8'h01;
        rx_i.head_data <= 8'hA5;
        @(posedge core_clk_i);
        rx_i.push <= 1'b0;
        rdc(3'h5, 8'h01, "data ready");
        chk_irq(1'b1);
        rdc(3'h0, 8'hA5, "rx data");
        rdc(3'h5, 8'h01, "ready kept");
        set_in(8'h00, 4'h0);
        rdc(3'h5, 8'h00, "ready cleared");
    endtask : t_ready

    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    // Main sequence, with a second reset at the end of the run
    initial begin
        t_reset();
        t_divisor();
        t_enhanced();
        t_fifo_irq();
        t_priority();
        t_ready();
        t_reset();
        end_sim();
    end

    // Hang guard
    initial begin
        #500000;
        fail_count++;
        end_sim();
    end
endmodule : uart_enhanced_regs_rx_interrupt_tb

`default_nettype wire
